// ### tb/uetc_card_model.sv
// uetc_card_model: serial peer or smart card on the tx pin
// assumes a baud tick per bit and a pull-up holding a released pin at mark
`timescale 1ns/1ps
module uetc_card_model (
  // line side
  input  wire logic       clock_i,
  input  wire logic       baud_en_i,
  input  wire logic       tx_i,
  input  wire logic       tx_oe_i,
  input  wire logic       inv_i,
  // card answer: reject the frame whose start count equals rej_i
  input  wire logic [7:0] rej_i,
  output logic            nack_o,
  // decoded traffic
  output logic [7:0]      starts_o,
  output logic [7:0]      frames_o,
  output logic [8:0]      frame_o
);
  logic       line;
  logic       line_q = 1'b1;
  logic [3:0] cnt_q  = 4'h0;
  // a floating pin reads as mark, never as the last driven level
  assign line   = tx_oe_i ? (tx_i ^ inv_i) : 1'b1;
  // nack is a level held from the rejected start to the next start
  assign nack_o = (starts_o == rej_i);
  initial starts_o = 8'h00;
  initial frames_o = 8'h00;
  // ---------------------------------------------------------------
  // decoder: tick 1 is the start bit, ticks 2..10 carry data lsb first
  // ---------------------------------------------------------------
  always @(posedge clock_i)
  begin
    line_q <= line;
    if (cnt_q == 4'h0)
    begin
      if (line_q && !line)
      begin
        cnt_q    <= 4'h1;
        starts_o <= starts_o + 8'h01;
      end
    end
    else if (baud_en_i)
    begin
      if (cnt_q >= 4'h2)
        frame_o[cnt_q - 4'h2] <= line;
      if (cnt_q == 4'ha)
        frames_o <= frames_o + 8'h01;
      cnt_q <= (cnt_q == 4'ha) ? 4'h0 : cnt_q + 4'h1;
    end
  end
endmodule : uetc_card_model

// ### tb/uetc_top_tb_top.sv
// uetc_top_tb_top: self-checking bench for the serial control options
// assumes the card model on the tx pin and a baud tick every 8 clocks
`timescale 1ns/1ps
module uetc_top_tb_top;
  import uetc_pkg::*;
  // ---------------------------------------------------------------
  // connections
  // ---------------------------------------------------------------
  logic               clock_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0]         addr_i = 8'h00, rej = 8'hff, starts, frames, f0;
  logic [31:0]        wdata_i = 32'h0, rdata_o, r, c;
  logic               rx_frame_valid_i = 1'b0, rx_parity_err_i = 1'b0, rx_framing_err_i = 1'b0;
  logic [UETC_FW-1:0] rx_frame_i = 9'h000, frame, ex;
  logic               baud_en_i = 1'b0, dma_req_raw_i = 1'b0, inv = 1'b0;
  logic               sc_nack_i, dma_req_o, tx_o, tx_oe_o, smartcard_enable_o, rx_enabled_o, irq_o;
  logic [1:0]         irq_seen;
  logic [2:0]         bc = 3'h0;
  int                 seed = 29540, bad_count = 0, total_checks = 0, k;

  uetc_top i_uetc_top (.clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_frame_valid_i(rx_frame_valid_i),
    .rx_frame_i(rx_frame_i), .rx_parity_err_i(rx_parity_err_i), .rx_framing_err_i(rx_framing_err_i),
    .sc_nack_i(sc_nack_i), .baud_en_i(baud_en_i), .dma_req_raw_i(dma_req_raw_i), .dma_req_o(dma_req_o),
    .tx_o(tx_o), .tx_oe_o(tx_oe_o), .smartcard_enable_o(smartcard_enable_o),
    .rx_enabled_o(rx_enabled_o), .irq_o(irq_o));
  uetc_card_model i_uetc_card_model (.clock_i(clock_i), .baud_en_i(baud_en_i), .tx_i(tx_o),
    .tx_oe_i(tx_oe_o), .inv_i(inv), .rej_i(rej), .nack_o(sc_nack_i), .starts_o(starts),
    .frames_o(frames), .frame_o(frame));

  // 20 mhz clock and a free bit tick, one clock in eight
  initial
  begin
    forever #25 clock_i = ~clock_i;
  end
  always @(posedge clock_i)
  begin
    bc        <= bc + 3'h1;
    baud_en_i <= (bc == 3'h7);
  end
  // ---------------------------------------------------------------
  // expectations and bus tasks
  // ---------------------------------------------------------------
  function automatic logic [8:0] exp_d8(input logic [7:0] b, input logic nine, input logic dv);
    return {nine & dv, b};
  endfunction : exp_d8
  // {output enable, driven level} of an idle pin
  function automatic logic [1:0] exp_idle(input logic iv, input logic au);
    return au ? 2'b00 : {1'b1, ~iv};
  endfunction : exp_idle
  // error side effects bite only with the option on in async mode
  function automatic logic exp_kept(input logic opt, input logic sync);
    return !(opt && !sync);
  endfunction : exp_kept
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  task automatic rxf(input logic [8:0] d, input logic pe, input logic fe);
    @(posedge clock_i);
    rx_frame_valid_i <= 1'b1;
    rx_frame_i       <= d;
    rx_parity_err_i  <= pe;
    rx_framing_err_i <= fe;
    @(posedge clock_i);
    rx_frame_valid_i <= 1'b0;
  endtask : rxf
  task automatic settle();
    repeat (2) @(posedge clock_i);
    #1;
  endtask : settle
  task automatic wait_frames(input logic [7:0] n);
    for (int i = 0; i < 600 && frames !== n; i++)
      @(posedge clock_i);
    chk(32'(frames), 32'(n));
  endtask : wait_frames
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clock_i);
    rst_b_i <= 1'b1;
    rd(UETC_ADDR_CTRL, r);
    chk(r, UETC_CTRL_RST);
    chk({30'h0, tx_oe_o, tx_o}, 32'h3);
    rd(8'hfc, r);
    chk(r, 32'h0);
    for (k = 1; k >= 0; k--)
    begin
      wr(UETC_ADDR_CTRL, 32'(k) << UETC_B_SCEN);
      settle();
      chk(32'(smartcard_enable_o), 32'(k));
    end
    // idle pin over inversion and auto tristate
    for (k = 0; k < 4; k++)
    begin
      wr(UETC_ADDR_CTRL, (32'(k & 1) << UETC_B_TX_OUTPUT_INVERT) | (32'(k >> 1) << UETC_B_AUTOTR));
      settle();
      chk(32'({tx_oe_o, tx_oe_o & tx_o}), 32'(exp_idle(k[0], k[1])));
      rd(UETC_ADDR_STATUS, r);
      chk(32'(r[1]), 32'(k[1]));
    end
    // random frames; the first two force eight-bit writes into nine-bit frames
    for (k = 0; k < 8; k++)
    begin
      c = $random(seed);
      if (k < 2)
        c[4:1] = {1'b1, c[3], k[0], 1'b1};
      wr(UETC_ADDR_CTRL, (32'h1 << UETC_B_TXEN) | (32'(c[0]) << UETC_B_TX_OUTPUT_INVERT) | (32'(c[1]) << UETC_B_NINE)
         | (32'(c[2]) << UETC_B_NINEDV) | (32'(c[3]) << UETC_B_AUTOTR));
      inv <= c[0];
      // the model may take the level change for a start; let it run out
      repeat (100) @(posedge clock_i);
      f0 = frames;
      wr(c[4] ? UETC_ADDR_TXD8 : UETC_ADDR_TXDATA, c >> 8);
      ex = c[4] ? exp_d8(c[15:8], c[1], c[2]) : {c[1] & c[16], c[15:8]};
      repeat (40) @(posedge clock_i);
      chk(32'(tx_oe_o), 32'h1);
      wait_frames(f0 + 8'h1);
      chk(32'(frame), 32'(ex));
      repeat (30) @(posedge clock_i);
      chk(32'(tx_oe_o), 32'(!c[3]));
    end
    // card rejects one frame, with and without retransmit
    for (k = 0; k < 2; k++)
    begin
      wr(UETC_ADDR_CTRL, (32'h1 << UETC_B_TXEN) | (32'h1 << UETC_B_SCEN) | (32'(k) << UETC_B_SCRT));
      inv <= 1'b0;
      repeat (100) @(posedge clock_i);
      f0  = frames;
      rej <= starts + 8'h1;
      c   = $random(seed);
      wr(UETC_ADDR_TXDATA, c);
      wait_frames(f0 + 8'(k + 1));
      chk(32'(frame), 32'(c[7:0]));
      repeat (200) @(posedge clock_i);
      chk(32'(frames), 32'(f0 + 8'(k + 1)));
      rd(UETC_ADDR_IRQ, r);
      // a frame resent with success ends without the nack flag
      chk(32'(r[UETC_I_NACK]), 32'(k == 0));
      rej <= 8'hff;
    end
    // receive errors against the disable option and sync mode
    for (k = 0; k < 4; k++)
    begin
      c = $random(seed);
      wr(UETC_ADDR_CTRL, (32'h1 << UETC_B_RXEN) | (32'(k & 1) << UETC_B_RXDOE) | (32'(k >> 1) << UETC_B_SYNC));
      rxf(c[8:0], c[9], !c[9]);
      settle();
      chk(32'(rx_enabled_o), 32'(exp_kept(k[0], k[1])));
    end
    // dma gating while an error flag stands, released by the clearing read
    dma_req_raw_i <= 1'b1;
    for (k = 0; k < 4; k++)
    begin
      c = $random(seed);
      wr(UETC_ADDR_CTRL, (32'h1 << UETC_B_RXEN) | (32'(k & 1) << UETC_B_DMAHLT) | (32'(k >> 1) << UETC_B_SYNC));
      rd(UETC_ADDR_IRQ, r);
      rxf(c[8:0], c[9], !c[9]);
      repeat (4) @(posedge clock_i);
      chk(32'(dma_req_o), 32'(exp_kept(k[0], k[1])));
      rd(UETC_ADDR_IRQ, r);
      settle();
      chk(32'(dma_req_o), 32'h1);
    end
    // parity-error frame after a good one, skipping off and on
    for (k = 0; k < 2; k++)
    begin
      c = $random(seed);
      wr(UETC_ADDR_CTRL, (32'h1 << UETC_B_RXEN) | (32'(k) << UETC_B_SKIPPE));
      rxf(c[8:0], 1'b0, 1'b0);
      rxf(c[24:16], 1'b1, 1'b0);
      rd(UETC_ADDR_RXDATA, r);
      chk(r & 32'h1ff, 32'(k ? c[8:0] : c[24:16]));
      rd(UETC_ADDR_IRQ, r);
      chk(32'(r[UETC_I_PARITY_ERROR_FLAG]), 32'h1);
    end
    // interrupt line with the mask open and shut, dropped by the read
    for (k = 0; k < 2; k++)
    begin
      wr(UETC_ADDR_MASK, k ? 32'h1f : 32'h0);
      rd(UETC_ADDR_MASK, r);
      chk(r, k ? 32'h1f : 32'h0);
      rd(UETC_ADDR_IRQ, r);
      rxf(9'h055, 1'b0, 1'b0);
      settle();
      irq_seen[k] = irq_o;
      rd(UETC_ADDR_IRQ, r);
      chk(32'(r[UETC_I_RXDV]), 32'h1);
      settle();
      chk(32'(irq_o), 32'h0);
    end
    chk(32'(irq_seen[0] ^ irq_seen[1]), 32'h1);
    final_report();
  end
  // watchdog: the sequence needs about 3000 clocks
  initial
  begin
    #(50 * 20000);
    bad_count++;
    final_report();
  end
endmodule : uetc_top_tb_top

// ### verilog/uetc_err_gate.sv
// uetc_err_gate: receive error policy and dma gating
// assumes frame events arrive as one-cycle pulses from the receiver
`timescale 1ns/1ps
module uetc_err_gate
  import uetc_pkg::*;
(
  // error policy controls
  input  wire logic sync_mode_i,
  input  wire logic rx_disable_on_error_i,
  input  wire logic dma_halt_on_error_i,
  input  wire logic skip_parity_error_frames_i,
  // live error flags and received frame
  input  wire logic parity_error_flag_i,
  input  wire logic framing_error_flag_i,
  input  wire logic rx_frame_valid_i,
  input  wire logic rx_parity_err_i,
  input  wire logic rx_framing_err_i,
  input  wire logic dma_req_raw_i,
  // decisions
  output logic      rx_kill_o,
  output logic      store_frame_o,
  output logic      dma_req_o
);
  // error side effects apply to async operation only
  always_comb
  begin
    rx_kill_o     = rx_frame_valid_i && rx_disable_on_error_i && !sync_mode_i &&
                    (rx_parity_err_i || rx_framing_err_i);
    store_frame_o = rx_frame_valid_i &&
                    !(skip_parity_error_frames_i && !sync_mode_i && rx_parity_err_i);
    dma_req_o     = dma_req_raw_i && !(dma_halt_on_error_i && !sync_mode_i &&
                    (parity_error_flag_i || framing_error_flag_i));
  end
endmodule : uetc_err_gate

// ### verilog/uetc_pkg.sv
// uetc_pkg: constants for the serial error / smart card / tristate control block
// assumes a single 20 MHz clock and a simple strobe register port
package uetc_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] UETC_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] UETC_ADDR_TXDATA = 8'h04;
  localparam logic [7:0] UETC_ADDR_TXD8   = 8'h08;
  localparam logic [7:0] UETC_ADDR_STATUS = 8'h0c;
  localparam logic [7:0] UETC_ADDR_IRQ    = 8'h10;
  localparam logic [7:0] UETC_ADDR_MASK   = 8'h14;
  localparam logic [7:0] UETC_ADDR_RXDATA = 8'h18;

  // ------------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------------
  localparam int UETC_B_SYNC   = 0;
  localparam int UETC_B_TXEN   = 1;
  localparam int UETC_B_RXEN   = 2;
  localparam int UETC_B_NINE   = 3;
  localparam int UETC_B_TX_OUTPUT_INVERT  = 14;
  localparam int UETC_B_AUTOTR = 17;
  localparam int UETC_B_SCEN   = 18;
  localparam int UETC_B_SCRT   = 19;
  localparam int UETC_B_SKIPPE = 20;
  localparam int UETC_B_NINEDV = 21;
  localparam int UETC_B_DMAHLT = 22;
  localparam int UETC_B_RXDOE  = 23;
  localparam logic [31:0] UETC_CTRL_RST = 32'h0000_0000;

  // irq / status bits
  localparam int UETC_I_PARITY_ERROR_FLAG = 0;
  localparam int UETC_I_FRAMING_ERROR_FLAG = 1;
  localparam int UETC_I_RXDV = 2;
  localparam int UETC_I_TXDN = 3;
  localparam int UETC_I_NACK = 4;
  localparam int UETC_NIRQ   = 5;

  localparam int UETC_FW = 9;
  localparam logic [3:0] UETC_FRAME_BITS = 4'hb;
  localparam logic [UETC_FW-1:0] UETC_ZERO_FRAME = 9'h000;
endpackage : uetc_pkg

// ### verilog/uetc_top.sv
// uetc_top: serial transceiver control options - error policy, dma halt,
// ninth bit default, parity frame skip, smart card retransmit, tx tristate
// assumes receiver events arrive as pulses and a baud enable from a divider
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps

module uetc_top
  import uetc_pkg::*;
(
  // clock and reset
  input  wire logic               clock_i,
  input  wire logic               rst_b_i,
  // register port
  input  wire logic [7:0]         addr_i,
  input  wire logic [31:0]        wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output logic      [31:0]        rdata_o,
  // receiver events
  input  wire logic               rx_frame_valid_i,
  input  wire logic [UETC_FW-1:0] rx_frame_i,
  input  wire logic               rx_parity_err_i,
  input  wire logic               rx_framing_err_i,
  input  wire logic               sc_nack_i,
  input  wire logic               baud_en_i,
  // dma
  input  wire logic               dma_req_raw_i,
  output logic                    dma_req_o,
  // line and status
  output logic                    tx_o,
  output logic                    tx_oe_o,
  output logic                    smartcard_enable_o,
  output logic                    rx_enabled_o,
  output logic                    irq_o
);
  import uetc_pkg::*;

  typedef struct packed {
    logic [31:0]          ctrl;
    logic [UETC_NIRQ-1:0] flags;
    logic [UETC_NIRQ-1:0] mask;
    logic [UETC_FW-1:0]   rxbuf;
    logic                 tx_pend;
    logic [UETC_FW-1:0]   tx_hold;
    logic                 tri_ctl;
    logic [31:0]          rdata;
    logic                 dma;
    logic                 tx;
    logic                 oe;
    logic                 irq;
  } uetc_st_t;

  uetc_st_t st_q, st_d;

  logic rx_kill;
  logic store_frame;
  logic dma_gated;
  logic sh_busy;
  logic sh_done;
  logic sh_bit;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // builds a nine-bit frame from a write, the top bit chosen by width of access in nine-bit mode, zero otherwise
  function automatic logic [UETC_FW-1:0] uetc_frame(input logic [31:0] w, input logic eight,
                                                    input logic nine, input logic dv);
    logic top;
    top = eight ? dv : w[UETC_FW-1];
    uetc_frame = nine ? {top, w[7:0]} : {1'b0, w[7:0]};
  endfunction : uetc_frame

  // ------------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------------
  uetc_err_gate u_err
  (
    .sync_mode_i                (st_q.ctrl[UETC_B_SYNC]),
    .rx_disable_on_error_i      (st_q.ctrl[UETC_B_RXDOE]),
    .dma_halt_on_error_i        (st_q.ctrl[UETC_B_DMAHLT]),
    .skip_parity_error_frames_i (st_q.ctrl[UETC_B_SKIPPE]),
    .parity_error_flag_i        (st_q.flags[UETC_I_PARITY_ERROR_FLAG]),
    .framing_error_flag_i       (st_q.flags[UETC_I_FRAMING_ERROR_FLAG]),
    .rx_frame_valid_i           (rx_frame_valid_i && st_q.ctrl[UETC_B_RXEN]),
    .rx_parity_err_i            (rx_parity_err_i),
    .rx_framing_err_i           (rx_framing_err_i),
    .dma_req_raw_i              (dma_req_raw_i),
    .rx_kill_o                  (rx_kill),
    .store_frame_o              (store_frame),
    .dma_req_o                  (dma_gated)
  );

  uetc_tx_shift u_tx
  (
    .clock_i      (clock_i),
    .rst_b_i      (rst_b_i),
    .baud_en_i    (baud_en_i),
    .tx_enable_i  (st_q.ctrl[UETC_B_TXEN]),
    .retransmit_i (st_q.ctrl[UETC_B_SCRT] && st_q.ctrl[UETC_B_SCEN]),
    .nack_i       (sc_nack_i),
    .load_i       (st_q.tx_pend && st_q.ctrl[UETC_B_TXEN] && baud_en_i), // start only on a bit tick
    .load_data_i  (st_q.tx_hold),
    .busy_o       (sh_busy),
    .done_o       (sh_done),
    .bit_o        (sh_bit)
  );

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    logic [UETC_NIRQ-1:0] ev;
    ev   = '0;
    st_d = st_q;
    st_d.rdata = 32'h0000_0000;

    // register writes
    if (wr_i)
    begin
      if (addr_i == UETC_ADDR_CTRL)
        st_d.ctrl = wdata_i;
      else if (addr_i == UETC_ADDR_MASK)
        st_d.mask = wdata_i[UETC_NIRQ-1:0];
      else if ((addr_i == UETC_ADDR_TXDATA || addr_i == UETC_ADDR_TXD8) && !st_q.tx_pend)
      begin
        st_d.tx_hold = uetc_frame(wdata_i, addr_i == UETC_ADDR_TXD8,
                                  st_q.ctrl[UETC_B_NINE], st_q.ctrl[UETC_B_NINEDV]);
        st_d.tx_pend = 1'b1;
      end
    end

    // hand the held frame over on a bit tick, so the start bit lasts a whole bit
    if (st_q.tx_pend && st_q.ctrl[UETC_B_TXEN] && !sh_busy && baud_en_i)
      st_d.tx_pend = 1'b0;

    // receiver side effects
    if (rx_frame_valid_i && st_q.ctrl[UETC_B_RXEN])
    begin
      ev[UETC_I_PARITY_ERROR_FLAG] = rx_parity_err_i;
      ev[UETC_I_FRAMING_ERROR_FLAG] = rx_framing_err_i;
    end
    if (store_frame)
    begin
      st_d.rxbuf      = rx_frame_i;
      ev[UETC_I_RXDV] = 1'b1;
    end
    if (rx_kill)
      st_d.ctrl[UETC_B_RXEN] = 1'b0;
    ev[UETC_I_TXDN] = sh_done;
    ev[UETC_I_NACK] = sh_done && sc_nack_i && st_q.ctrl[UETC_B_SCEN];

    // reads, flags clear on an irq register read but a new event still wins
    if (rd_i)
    begin
      if (addr_i == UETC_ADDR_CTRL)
        st_d.rdata = st_q.ctrl;
      else if (addr_i == UETC_ADDR_STATUS)
        st_d.rdata = {30'h0, st_q.tri_ctl, sh_busy};
      else if (addr_i == UETC_ADDR_IRQ)
      begin
        st_d.rdata = {{(32-UETC_NIRQ){1'b0}}, st_q.flags};
        st_d.flags = '0;
      end
      else if (addr_i == UETC_ADDR_MASK)
        st_d.rdata = {{(32-UETC_NIRQ){1'b0}}, st_q.mask};
      else if (addr_i == UETC_ADDR_RXDATA)
        st_d.rdata = {{(32-UETC_FW){1'b0}}, st_q.rxbuf};
    end
    st_d.flags = st_d.flags | ev;

    // tristate control follows transmitter activity when automatic
    if (st_q.ctrl[UETC_B_AUTOTR])
      st_d.tri_ctl = !(sh_busy || (st_q.tx_pend && st_q.ctrl[UETC_B_TXEN]));
    else
      st_d.tri_ctl = 1'b0;

    // pin: idle is the mark level, inverted when asked
    st_d.tx  = sh_bit ^ st_q.ctrl[UETC_B_TX_OUTPUT_INVERT];
    st_d.oe  = !st_d.tri_ctl;
    st_d.dma = dma_gated;
    st_d.irq = |(st_d.flags & st_d.mask);
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_q       <= '0;
      st_q.ctrl  <= UETC_CTRL_RST;
      st_q.tx    <= 1'b1;
      st_q.oe    <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign rdata_o            = st_q.rdata;
  assign dma_req_o          = st_q.dma;
  assign tx_o               = st_q.tx;
  assign tx_oe_o            = st_q.oe;
  assign smartcard_enable_o = st_q.ctrl[UETC_B_SCEN];
  assign rx_enabled_o       = st_q.ctrl[UETC_B_RXEN];
  assign irq_o              = st_q.irq;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_rx_kill;
    @(posedge clock_i) disable iff (!rst_b_i)
      (rx_frame_valid_i && st_q.ctrl[UETC_B_RXEN] && st_q.ctrl[UETC_B_RXDOE] && !st_q.ctrl[UETC_B_SYNC]
       && rx_framing_err_i && !(wr_i && addr_i == UETC_ADDR_CTRL)) |=> !rx_enabled_o;
  endproperty
  a_rx_kill: assert property (p_rx_kill) else $error("receiver not disabled on error");

  property p_rx_keep;
    @(posedge clock_i) disable iff (!rst_b_i)
      (st_q.ctrl[UETC_B_RXEN] && !st_q.ctrl[UETC_B_RXDOE] && !(wr_i && addr_i == UETC_ADDR_CTRL))
      |=> rx_enabled_o;
  endproperty
  a_rx_keep: assert property (p_rx_keep) else $error("receiver stopped without option");

  property p_dma_halt;
    @(posedge clock_i) disable iff (!rst_b_i)
      (st_q.ctrl[UETC_B_DMAHLT] && !st_q.ctrl[UETC_B_SYNC] && st_q.flags[UETC_I_PARITY_ERROR_FLAG]) |=> !dma_req_o;
  endproperty
  a_dma_halt: assert property (p_dma_halt) else $error("dma not held on error");

  property p_dma_sync;
    @(posedge clock_i) disable iff (!rst_b_i)
      (st_q.ctrl[UETC_B_SYNC] && dma_req_raw_i) |=> dma_req_o;
  endproperty
  a_dma_sync: assert property (p_dma_sync) else $error("dma held in sync mode");

  property p_skip;
    @(posedge clock_i) disable iff (!rst_b_i)
      (rx_frame_valid_i && st_q.ctrl[UETC_B_RXEN] && st_q.ctrl[UETC_B_SKIPPE] && !st_q.ctrl[UETC_B_SYNC]
       && rx_parity_err_i) |=> (st_q.rxbuf == $past(st_q.rxbuf)) && st_q.flags[UETC_I_PARITY_ERROR_FLAG];
  endproperty
  a_skip: assert property (p_skip) else $error("parity frame stored or flag lost");

  property p_ninth;
    @(posedge clock_i) disable iff (!rst_b_i)
      (wr_i && addr_i == UETC_ADDR_TXD8 && !st_q.tx_pend && st_q.ctrl[UETC_B_NINE])
      |=> st_q.tx_hold[UETC_FW-1] == $past(st_q.ctrl[UETC_B_NINEDV]);
  endproperty
  a_ninth: assert property (p_ninth) else $error("ninth bit not from default");

  property p_tri_idle;
    @(posedge clock_i) disable iff (!rst_b_i)
      (st_q.ctrl[UETC_B_AUTOTR] && !sh_busy && !st_q.tx_pend) |=> !tx_oe_o;
  endproperty
  a_tri_idle: assert property (p_tri_idle) else $error("pin driven while idle with auto tristate");

  property p_drive_busy;
    @(posedge clock_i) disable iff (!rst_b_i)
      sh_busy |=> tx_oe_o;
  endproperty
  a_drive_busy: assert property (p_drive_busy) else $error("pin floated during transmission");

  property p_idle_level;
    @(posedge clock_i) disable iff (!rst_b_i)
      (!st_q.ctrl[UETC_B_AUTOTR] && !sh_busy) |=> tx_oe_o && (tx_o == !$past(st_q.ctrl[UETC_B_TX_OUTPUT_INVERT]));
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle level wrong");
endmodule : uetc_top

// ### verilog/uetc_tx_shift.sv
// uetc_tx_shift: frame shifter with smart card retransmit
// assumes one baud enable pulse per bit time and an nack level from the line, sampled at the stop bit tick
`timescale 1ns/1ps
module uetc_tx_shift
  import uetc_pkg::*;
(
  input  wire logic               clock_i,
  input  wire logic               rst_b_i,
  // control
  input  wire logic               baud_en_i,
  input  wire logic               tx_enable_i,
  input  wire logic               retransmit_i,
  input  wire logic               nack_i,
  // load
  input  wire logic               load_i,
  input  wire logic [UETC_FW-1:0] load_data_i,
  // status
  output logic                    busy_o,
  output logic                    done_o,
  output logic                    bit_o
);
  import uetc_pkg::*;

  typedef struct packed {
    logic               busy;
    logic               done;
    logic [3:0]         cnt;
    logic [UETC_FW-1:0] keep;
    logic [UETC_FW+1:0] sh;
  } uetc_sh_t;

  uetc_sh_t s_q, s_d;

  // ------------------------------------------------------------------
  // shifter: start bit, 9 data bits, stop bit, lsb first
  // ------------------------------------------------------------------
  always_comb
  begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (!s_q.busy && load_i)
    begin
      s_d.busy = 1'b1;
      s_d.keep = load_data_i;
      s_d.sh   = {1'b1, load_data_i, 1'b0};
      s_d.cnt  = 4'h0;
    end
    else if (s_q.busy && baud_en_i)
    begin
      if (s_q.cnt == UETC_FRAME_BITS - 4'h1)
      begin
        // a rejected frame stays put and goes again while the transmitter is on
        if (retransmit_i && nack_i && tx_enable_i)
        begin
          s_d.sh  = {1'b1, s_q.keep, 1'b0};
          s_d.cnt = 4'h0;
        end
        else
        begin
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
        end
      end
      else
      begin
        s_d.sh  = {1'b1, s_q.sh[UETC_FW+1:1]};
        s_d.cnt = s_q.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      s_q <= '{busy: 1'b0, done: 1'b0, cnt: 4'h0, keep: UETC_ZERO_FRAME, sh: '1};
    else
      s_q <= s_d;
  end

  assign busy_o = s_q.busy;
  assign done_o = s_q.done;
  assign bit_o  = s_q.busy ? s_q.sh[0] : 1'b1;
endmodule : uetc_tx_shift
